//--- src/flash_seq_params.svh
// Purpose: constants of the flash protect/write sequencer
// Assumes: 50 MHz system clock
// Notes: definitions only
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_STATUS 8'h0c

// ----------------------------------------
// status register field positions
// ----------------------------------------
`define STS_SEQ_BUSY 0
`define STS_BOOT_DONE 1
`define STS_LOCK 2
`define STS_FLASH_LSB 8
`define STS_RDATA_LSB 16

// ----------------------------------------
// flash status byte bits
// ----------------------------------------
`define FLASH_BUSY_BIT 0
`define WRITE_LATCH_BIT 1
`define STATUS_LOCK_BIT 7

// ----------------------------------------
// flash opcodes
// ----------------------------------------
`define OPC_WRITE_ENABLE 8'h06
`define OPC_STATUS_READ 8'h05
`define OPC_STATUS_WRITE 8'h01
`define OPC_PAGE_PROGRAM 8'h02
`define OPC_SECTOR_ERASE 8'h20
`define OPC_CHIP_ERASE 8'hc7
`define OPC_FAST_READ 8'h0b
`define STATUS_CLEAR_VALUE 8'h00
`define DUMMY_BYTE 8'h00

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 50
`define T_DESELECT_NS 200
`define DESELECT_CYC (((`T_DESELECT_NS * `CLK_MHZ) + 999) / 1000)
`define SCK_HALF_CYC 3
`define BYTE_LAST_BIT 7

// ----------------------------------------
// last byte index of each frame
// ----------------------------------------
`define FRAME_LAST_CMD 0
`define FRAME_LAST_STATUS 1
`define FRAME_LAST_SECT 3
`define FRAME_LAST_PROG 4
`define FRAME_LAST_READ 5

`endif

//--- src/flash_seq_pkg.sv
// Purpose: types of the flash protect/write sequencer
// Assumes: nothing
// Notes: constants live in flash_seq_params.svh
package flash_seq_pkg;

	// ----------------------------------------
	// sequencer states, one-hot
	// ----------------------------------------
	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_WRITE_ENABLE = 5'h02,
		ST_POLL_LATCH = 5'h04,
		ST_MAIN = 5'h08,
		ST_POLL_BUSY = 5'h10
	} seq_state_t;

	// ----------------------------------------
	// operations
	// ----------------------------------------
	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_PROG = 3'h1,
		OP_SECT = 3'h2,
		OP_CHIP = 3'h3,
		OP_READ = 3'h4,
		OP_CLRPROT = 3'h5
	} flash_op_t;

	// ----------------------------------------
	// state of the byte shifter
	// ----------------------------------------
	typedef struct packed {
		logic active;
		logic sck;
		logic done;
		logic [3:0] half_cnt;
		logic [2:0] bit_cnt;
		logic [7:0] sh;
		logic [7:0] rx;
	} shifter_state_t;

	// ----------------------------------------
	// state of the sequencer
	// ----------------------------------------
	typedef struct packed {
		seq_state_t state;
		flash_op_t op;
		logic boot_done;
		logic cs_n;
		logic frame_on;
		logic gap;
		logic [7:0] gap_cnt;
		logic [2:0] byte_idx;
		logic start;
		logic ack;
		logic [31:0] rdata;
		logic [23:0] addr;
		logic [7:0] wdata;
		logic [7:0] fstat;
		logic [7:0] rd_byte;
	} seq_reg_t;

endpackage

//--- src/bit_sync.sv
// Purpose: two-flop synchroniser for one pin input
// Assumes: input is asynchronous to clk_i
// Notes: first flop feeds only the second
`timescale 1ns/1ns
`default_nettype none

module bit_sync (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// data
	input wire logic d_i,
	output logic q_o
);

	logic [1:0] sync_reg;
	logic [1:0] sync_next;

	always_comb begin
		sync_next = {sync_reg[0], d_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync_reg <= 2'h0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	assign q_o = sync_reg[1];

endmodule

`default_nettype wire

//--- src/spi_byte_shifter.sv
// Purpose: one-byte full-duplex exchange, single line each way
// Assumes: miso_i already synchronised
// Notes: msb first, sck idles low
`timescale 1ns/1ns
`default_nettype none

`include "flash_seq_params.svh"

module spi_byte_shifter #(
	parameter logic [3:0] HALF = 4'(`SCK_HALF_CYC)
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// byte request
	input wire logic start_i,
	input wire logic [7:0] tx_i,
	output logic done_o,
	output logic [7:0] rx_o,
	// serial pins
	output logic sck_o,
	output logic mosi_o,
	input wire logic miso_i
);

	flash_seq_pkg::shifter_state_t s_reg;
	flash_seq_pkg::shifter_state_t s_next;

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		if (start_i && !s_reg.active) begin
			s_next.active = 1'b1;
			s_next.sck = 1'b0;
			s_next.sh = tx_i;
			s_next.half_cnt = 4'h0;
			s_next.bit_cnt = 3'h0;
		end else if (s_reg.active) begin
			if (s_reg.half_cnt == HALF - 4'h1) begin
				s_next.half_cnt = 4'h0;
				if (!s_reg.sck) begin
					s_next.sck = 1'b1;
				end else begin
					s_next.sck = 1'b0;
					s_next.rx = {s_reg.rx[6:0], miso_i};
					if (s_reg.bit_cnt == 3'(`BYTE_LAST_BIT)) begin
						s_next.active = 1'b0;
						s_next.done = 1'b1;
					end else begin
						s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
						s_next.sh = {s_reg.sh[6:0], 1'b0};
					end
				end
			end else begin
				s_next.half_cnt = s_reg.half_cnt + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done_o = s_reg.done;
	assign rx_o = s_reg.rx;
	assign sck_o = s_reg.sck;
	assign mosi_o = s_reg.sh[7];

endmodule

`default_nettype wire

//--- src/spi_flash_protect_write_sequencer.sv
// Purpose: serial flash command sequencer with boot-time unprotect
// Assumes: classic wishbone slave, 50 MHz clock
// Notes: one status byte only; one data byte per program or read
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none

`include "flash_seq_params.svh"

// Function
// - the flash link uses one data line each way in mode 0, clock idle low and sampled on the rising edge.
// - bit 0 of the flash status byte is read as the busy flag.
// - bit 1 of the flash status byte is read as the write-enable latch.
// - bit 7 of the flash status byte is read as the lock flag of the status register itself.
// - status read and status write frames carry exactly one status byte, never an expansion byte.
// - the sequencer always assumes protection is on at power-up and always runs the clearing sequence at boot.
// - at boot it sends write-enable and then status reads until the write-enable latch reads set.
// - with the latch seen set at boot it sends a status write of eight zero bits.
// - before each program or erase it sends write-enable and polls status until the latch is set.
// - the program or erase command goes out only after a status read showed the latch set.
module spi_flash_protect_write_sequencer (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// serial flash
	output logic flash_sck_o,
	output logic flash_mosi_o,
	output logic flash_cs_n_o,
	input wire logic flash_miso_i,
	// status
	output logic boot_done_o
);

	flash_seq_pkg::seq_reg_t r_reg;
	flash_seq_pkg::seq_reg_t r_next;
	logic miso_sync;
	logic sh_done;
	logic [7:0] sh_rx;
	logic [7:0] tx_byte;
	logic [31:0] addr_merged;
	logic [31:0] wdata_merged;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic seq_busy(input flash_seq_pkg::seq_state_t st, input logic gap);
		return (st != flash_seq_pkg::ST_IDLE) || gap;
	endfunction

	function automatic logic op_startable(input logic [2:0] code);
		return (code >= 3'(flash_seq_pkg::OP_PROG)) && (code <= 3'(flash_seq_pkg::OP_READ));
	endfunction

	function automatic logic [2:0] last_idx(input flash_seq_pkg::seq_state_t st, input flash_seq_pkg::flash_op_t op);
		logic [2:0] n;
		n = 3'(`FRAME_LAST_CMD);
		case (st)
			flash_seq_pkg::ST_WRITE_ENABLE: begin
				n = 3'(`FRAME_LAST_CMD);
			end
			flash_seq_pkg::ST_POLL_LATCH, flash_seq_pkg::ST_POLL_BUSY: begin
				n = 3'(`FRAME_LAST_STATUS);
			end
			flash_seq_pkg::ST_MAIN: begin
				case (op)
					flash_seq_pkg::OP_CLRPROT: n = 3'(`FRAME_LAST_STATUS);
					flash_seq_pkg::OP_PROG: n = 3'(`FRAME_LAST_PROG);
					flash_seq_pkg::OP_SECT: n = 3'(`FRAME_LAST_SECT);
					flash_seq_pkg::OP_READ: n = 3'(`FRAME_LAST_READ);
					default: n = 3'(`FRAME_LAST_CMD);
				endcase
			end
			default: begin
				n = 3'(`FRAME_LAST_CMD);
			end
		endcase
		return n;
	endfunction

	function automatic logic [7:0] frame_byte(input flash_seq_pkg::seq_state_t st, input flash_seq_pkg::flash_op_t op,
		input logic [2:0] idx, input logic [23:0] a, input logic [7:0] d);
		logic [7:0] b;
		b = `DUMMY_BYTE;
		case (st)
			flash_seq_pkg::ST_WRITE_ENABLE: begin
				b = `OPC_WRITE_ENABLE;
			end
			flash_seq_pkg::ST_POLL_LATCH, flash_seq_pkg::ST_POLL_BUSY: begin
				b = (idx == 3'h0) ? `OPC_STATUS_READ : `DUMMY_BYTE;
			end
			flash_seq_pkg::ST_MAIN: begin
				case (idx)
					3'h0: begin
						case (op)
							flash_seq_pkg::OP_CLRPROT: b = `OPC_STATUS_WRITE;
							flash_seq_pkg::OP_PROG: b = `OPC_PAGE_PROGRAM;
							flash_seq_pkg::OP_SECT: b = `OPC_SECTOR_ERASE;
							flash_seq_pkg::OP_CHIP: b = `OPC_CHIP_ERASE;
							flash_seq_pkg::OP_READ: b = `OPC_FAST_READ;
							default: b = `DUMMY_BYTE;
						endcase
					end
					3'h1: b = (op == flash_seq_pkg::OP_CLRPROT) ? `STATUS_CLEAR_VALUE : a[23:16];
					3'h2: b = a[15:8];
					3'h3: b = a[7:0];
					3'h4: b = (op == flash_seq_pkg::OP_PROG) ? d : `DUMMY_BYTE;
					default: b = `DUMMY_BYTE;
				endcase
			end
			default: begin
				b = `DUMMY_BYTE;
			end
		endcase
		return b;
	endfunction

	// ----------------------------------------
	// byte-lane merge
	// ----------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = d[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// ----------------------------------------
	// sub-blocks
	// ----------------------------------------
	bit_sync u_bit_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.d_i(flash_miso_i),
		.q_o(miso_sync)
	);

	assign tx_byte = frame_byte(r_reg.state, r_reg.op, r_reg.byte_idx, r_reg.addr, r_reg.wdata);

	spi_byte_shifter u_spi_byte_shifter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.start_i(r_reg.start),
		.tx_i(tx_byte),
		.done_o(sh_done),
		.rx_o(sh_rx),
		.sck_o(flash_sck_o),
		.mosi_o(flash_mosi_o),
		.miso_i(miso_sync)
	);

	assign addr_merged = merge({8'h00, r_reg.addr}, wb_dat_i, wb_sel_i);
	assign wdata_merged = merge({24'h000000, r_reg.wdata}, wb_dat_i, wb_sel_i);

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.start = 1'b0;
		r_next.ack = 1'b0;

		// ----------------------------------------
		// bus access
		// ----------------------------------------
		if (wb_cyc_i && wb_stb_i && !r_reg.ack) begin
			r_next.ack = 1'b1;
			r_next.rdata = 32'h00000000;
			if (wb_we_i) begin
				case (wb_adr_i)
					`REG_CTRL: begin
						if (wb_sel_i[0] && r_reg.boot_done && !seq_busy(r_reg.state, r_reg.gap)
							&& op_startable(wb_dat_i[2:0])) begin
							r_next.op = flash_seq_pkg::flash_op_t'(wb_dat_i[2:0]);
							r_next.state = (wb_dat_i[2:0] == 3'(flash_seq_pkg::OP_READ)) ? flash_seq_pkg::ST_MAIN
								: flash_seq_pkg::ST_WRITE_ENABLE;
							r_next.gap = 1'b1;
							r_next.gap_cnt = 8'(`DESELECT_CYC);
						end
					end
					`REG_ADDR: r_next.addr = addr_merged[23:0];
					`REG_WDATA: r_next.wdata = wdata_merged[7:0];
					default: r_next.addr = r_reg.addr;
				endcase
			end else begin
				case (wb_adr_i)
					`REG_CTRL: r_next.rdata = {29'h00000000, r_reg.op};
					`REG_ADDR: r_next.rdata = {8'h00, r_reg.addr};
					`REG_WDATA: r_next.rdata = {24'h000000, r_reg.wdata};
					`REG_STATUS: begin
						r_next.rdata[`STS_SEQ_BUSY] = seq_busy(r_reg.state, r_reg.gap);
						r_next.rdata[`STS_BOOT_DONE] = r_reg.boot_done;
						r_next.rdata[`STS_LOCK] = r_reg.fstat[`STATUS_LOCK_BIT];
						r_next.rdata[`STS_FLASH_LSB +: 8] = r_reg.fstat;
						r_next.rdata[`STS_RDATA_LSB +: 8] = r_reg.rd_byte;
					end
					default: r_next.rdata = 32'h00000000;
				endcase
			end
		end

		// ----------------------------------------
		// chip-select high time, then frame open
		// ----------------------------------------
		if (r_reg.gap) begin
			if (r_reg.gap_cnt == 8'h00) begin
				r_next.gap = 1'b0;
				if (r_reg.state != flash_seq_pkg::ST_IDLE) begin
					r_next.cs_n = 1'b0;
					r_next.frame_on = 1'b1;
					r_next.byte_idx = 3'h0;
					r_next.start = 1'b1;
				end
			end else begin
				r_next.gap_cnt = r_reg.gap_cnt - 8'h01;
			end
		end

		// ----------------------------------------
		// byte finished
		// ----------------------------------------
		if (r_reg.frame_on && sh_done) begin
			if (r_reg.state == flash_seq_pkg::ST_MAIN && r_reg.op == flash_seq_pkg::OP_READ
				&& r_reg.byte_idx == 3'(`FRAME_LAST_READ)) begin
				r_next.rd_byte = sh_rx;
			end
			if (r_reg.byte_idx == last_idx(r_reg.state, r_reg.op)) begin
				r_next.cs_n = 1'b1;
				r_next.frame_on = 1'b0;
				r_next.gap = 1'b1;
				r_next.gap_cnt = 8'(`DESELECT_CYC);
				case (r_reg.state)
					flash_seq_pkg::ST_WRITE_ENABLE: begin
						r_next.state = flash_seq_pkg::ST_POLL_LATCH;
					end
					flash_seq_pkg::ST_POLL_LATCH: begin
						r_next.fstat = sh_rx;
						if (sh_rx[`WRITE_LATCH_BIT]) begin
							r_next.state = flash_seq_pkg::ST_MAIN;
						end
					end
					flash_seq_pkg::ST_MAIN: begin
						r_next.state = (r_reg.op == flash_seq_pkg::OP_READ) ? flash_seq_pkg::ST_IDLE
							: flash_seq_pkg::ST_POLL_BUSY;
					end
					flash_seq_pkg::ST_POLL_BUSY: begin
						r_next.fstat = sh_rx;
						if (!sh_rx[`FLASH_BUSY_BIT]) begin
							r_next.state = flash_seq_pkg::ST_IDLE;
							if (r_reg.op == flash_seq_pkg::OP_CLRPROT) begin
								r_next.boot_done = 1'b1;
							end
						end
					end
					default: begin
						r_next.state = flash_seq_pkg::ST_IDLE;
					end
				endcase
			end else begin
				r_next.byte_idx = r_reg.byte_idx + 3'h1;
				r_next.start = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_reg <= '0;
			r_reg.state <= flash_seq_pkg::ST_WRITE_ENABLE;
			r_reg.op <= flash_seq_pkg::OP_CLRPROT;
			r_reg.cs_n <= 1'b1;
			r_reg.gap <= 1'b1;
			r_reg.gap_cnt <= 8'(`DESELECT_CYC);
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_dat_o = r_reg.rdata;
	assign wb_ack_o = r_reg.ack;
	assign flash_cs_n_o = r_reg.cs_n;
	assign boot_done_o = r_reg.boot_done;

endmodule

`default_nettype wire

//--- tb/flash_model.sv
// Purpose: behavioural serial flash on the far side
// Assumes: mode 0, one data line each way
// Notes: protocol faults are counted in viol_o
`timescale 1ns/1ns
`default_nettype none

module flash_model (
	// serial pins
	input wire logic sck_i,
	input wire logic mosi_i,
	input wire logic cs_n_i,
	output logic miso_o,
	// control and report
	input wire logic [1:0] lag_i,
	output logic [7:0] st_o,
	output logic [7:0] op_o,
	output logic [7:0] wd_o,
	output logic [23:0] ad_o,
	output logic [7:0] nops_o,
	output logic [7:0] viol_o
);
	logic [47:0] fr = 48'h0;
	logic [7:0] tx = 8'h0;
	logic [7:0] op;
	logic seen = 1'h0;
	int n = 0;
	int len;
	int lag = 0;
	int busy = 0;

	initial begin
		st_o = 8'hfc;
		viol_o = 8'h0;
		nops_o = 8'h0;
	end
	// ----------------------------------------
	// serial shifting
	// ----------------------------------------
	assign miso_o = cs_n_i ? ~tx[7] : tx[7];
	always @(negedge cs_n_i) n = 0;
	always @(posedge sck_i) begin
		fr = {fr[46:0], mosi_i};
		n = n + 1;
	end
	always @(negedge sck_i) begin
		if (n == 8 && fr[7:0] == 8'h05) tx = st_o;
		else if (n == 40 && fr[39:32] == 8'h0b) tx = fr[15:8] ^ 8'h5a;
		else tx = {tx[6:0], ~tx[0]};
	end
	// ----------------------------------------
	// command at frame end
	// ----------------------------------------
	always @(posedge cs_n_i) if (n > 0) begin
		op = fr[n-1 -: 8];
		case (op)
			8'h06, 8'hc7: len = 8;
			8'h05, 8'h01: len = 16;
			8'h20: len = 32;
			8'h02: len = 40;
			8'h0b: len = 48;
			default: len = 0;
		endcase
		if (n != len) viol_o++;
		case (op)
			8'h06: begin
				if (st_o[0]) viol_o++;
				seen = 1'h0;
				lag = lag_i;
				if (lag == 0) st_o[1] = 1'h1;
			end
			8'h05: begin
				seen = st_o[1];
				if (busy > 0) busy--;
				if (busy == 0) st_o[0] = 1'h0;
				if (lag > 0) begin
					lag--;
					if (lag == 0) st_o[1] = 1'h1;
				end
			end
			8'h01: begin
				if (!seen) viol_o++;
				st_o = {fr[7:2], 2'h1};
				busy = 2;
				seen = 1'h0;
			end
			8'h0b: begin
				nops_o++;
				op_o = op;
				ad_o = fr[n-9 -: 24];
			end
			default: begin
				if (!seen || st_o[6:2] != 5'h0) viol_o++;
				nops_o++;
				op_o = op;
				ad_o = fr[n-9 -: 24];
				wd_o = fr[7:0];
				st_o[1:0] = 2'h1;
				busy = 2;
				seen = 1'h0;
			end
		endcase
	end
endmodule

`default_nettype wire

//--- tb/spi_flash_protect_write_sequencer_monitor.sv
// Purpose: port checker of the flash sequencer
// Assumes: one clock, synchronous reset
// Notes: bound to the top module
`timescale 1ns/1ns
`default_nettype none

module spi_flash_protect_write_sequencer_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	// serial flash
	input wire logic flash_sck_o,
	input wire logic flash_mosi_o,
	input wire logic flash_cs_n_o,
	// status
	input wire logic boot_done_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sequence s_sck_high;
		flash_sck_o [*3] ##1 !flash_sck_o;
	endsequence
	a_sck_idle_low: assert property (flash_cs_n_o |-> !flash_sck_o)
		else $error("sck active outside a frame");
	a_sck_half_len: assert property ($rose(flash_sck_o) |-> s_sck_high)
		else $error("sck high phase has wrong length");
	a_mosi_hold_high: assert property (flash_sck_o && $past(flash_sck_o) |-> $stable(flash_mosi_o))
		else $error("mosi moved while sck high");
	a_cs_gap_min: assert property ($rose(flash_cs_n_o) |-> flash_cs_n_o [*8])
		else $error("chip select gap too short");
	a_boot_low_first: assert property ($past(rst_i) |-> !boot_done_o)
		else $error("boot done without boot sequence");
	a_boot_done_held: assert property (boot_done_o |=> boot_done_o)
		else $error("boot done dropped");
	a_boot_frame_soon: assert property ($past(rst_i) |-> ##[1:20] !flash_cs_n_o)
		else $error("boot sequence did not start");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not acked in one cycle");
endmodule

bind spi_flash_protect_write_sequencer spi_flash_protect_write_sequencer_monitor u_mon (
	.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.flash_sck_o(flash_sck_o), .flash_mosi_o(flash_mosi_o), .flash_cs_n_o(flash_cs_n_o),
	.boot_done_o(boot_done_o)
);

`default_nettype wire

//--- tb/spi_flash_protect_write_sequencer_tb.sv
// Purpose: self-checking bench of the flash sequencer
// Assumes: flash_model on the serial pins
// Notes: reads are checked off a queue by a watcher
`timescale 1ns/1ns
`default_nettype none

module spi_flash_protect_write_sequencer_tb;
	logic clk_i = 1'h0;
	logic rst_i = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0;
	logic [1:0] lag = 2'h0;
	logic [31:0] dat_o, rd, a, d, m;
	logic ack, sck, mosi, cs_n, miso, boot;
	logic [7:0] st, fop, fwd, nops, viol, n0;
	logic [23:0] fad;
	logic [63:0] eq[$];
	logic [63:0] nt;
	logic [3:0] s;
	logic [7:0] opt[1:4] = '{8'h02, 8'h20, 8'hc7, 8'h0b};
	int mismatches = 0;
	int checked = 0;
	int cyc_cnt = 0;

	spi_flash_protect_write_sequencer u_spi_flash_protect_write_sequencer (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.flash_sck_o(sck), .flash_mosi_o(mosi), .flash_cs_n_o(cs_n), .flash_miso_i(miso),
		.boot_done_o(boot)
	);
	flash_model u_flash_model (
		.sck_i(sck), .mosi_i(mosi), .cs_n_i(cs_n), .miso_o(miso), .lag_i(lag),
		.st_o(st), .op_o(fop), .wd_o(fwd), .ad_o(fad), .nops_o(nops), .viol_o(viol)
	);

	initial forever #10 clk_i = ~clk_i;
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task automatic end_sim();
		$display("checked %0d, mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
		checked++;
		if (v !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", nm, e, v);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] sl, input logic [31:0] dt,
		input logic [31:0] mk, input logic [31:0] e);
		eq.push_back({mk, e & mk});
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= ad;
		sel <= sl;
		dat <= dt;
		do @(posedge clk_i); while (ack !== 1'h1);
		rd = dat_o;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	task automatic idle();
		do wb(1'h0, 8'h0c, 4'hf, 32'h0, 32'h0, 32'h0); while (rd[0] !== 1'h0);
	endtask
	task automatic run_op(input logic [2:0] o);
		a = {8'h0, 24'($urandom)};
		d = $urandom;
		lag <= 2'($urandom);
		n0 = nops;
		wb(1'h1, 8'h04, 4'hf, a, 32'h0, 32'h0);
		wb(1'h1, 8'h08, 4'hf, d, 32'h0, 32'h0);
		wb(1'h1, 8'h00, 4'h1, {29'h0, o}, 32'h0, 32'h0);
		wb(1'h1, 8'h00, 4'h1, 32'h2, 32'h0, 32'h0);
		idle();
		chk("op count", 32'(n0 + 8'h1), 32'(nops));
		chk("opcode", 32'(opt[o]), 32'(fop));
		chk("flash busy", 32'h0, 32'(st[0]));
		if (o != 3'h3) chk("address", 32'(a[23:0]), 32'(fad));
		if (o == 3'h1) chk("program data", 32'(d[7:0]), 32'(fwd));
		if (o == 3'h4) wb(1'h0, 8'h0c, 4'hf, 32'h0, 32'hff0000, {8'h0, a[7:0] ^ 8'h5a, 16'h0});
	endtask
	// ----------------------------------------
	// watcher and timeout
	// ----------------------------------------
	always @(posedge clk_i) begin
		if (ack === 1'h1 && eq.size() > 0) begin
			nt = eq.pop_front();
			if (nt[63:32] !== 32'h0) chk("wb read", nt[31:0], dat_o & nt[63:32]);
		end
	end
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			mismatches++;
			end_sim();
		end
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(32'h1205));
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
		wb(1'h1, 8'h00, 4'hf, 32'h1, 32'h0, 32'h0);
		wb(1'h0, 8'h04, 4'hf, 32'h0, 32'hffffff, 32'h0);
		wb(1'h0, 8'h08, 4'hf, 32'h0, 32'hff, 32'h0);
		wb(1'h1, 8'h40, 4'hf, 32'hffffffff, 32'h0, 32'h0);
		wb(1'h0, 8'h40, 4'hf, 32'h0, 32'hffffffff, 32'h0);
		a = $urandom;
		s = 4'($urandom);
		m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
		wb(1'h1, 8'h04, s, a, 32'h0, 32'h0);
		wb(1'h0, 8'h04, 4'hf, 32'h0, 32'hffffff, a & m);
		while (boot !== 1'h1) @(posedge clk_i);
		idle();
		chk("boot flash status", 32'h0, 32'(st));
		chk("faults", 32'h0, 32'(viol));
		chk("ops before boot", 32'h0, 32'(nops));
		wb(1'h0, 8'h0c, 4'hf, 32'h0, 32'hff07, 32'h2);
		for (int i = 0; i < 8; i++) run_op(3'(i % 4 + 1));
		n0 = nops;
		wb(1'h1, 8'h00, 4'he, 32'h1, 32'h0, 32'h0);
		wb(1'h1, 8'h00, 4'hf, 32'h0, 32'h0, 32'h0);
		wb(1'h1, 8'h00, 4'hf, 32'h5, 32'h0, 32'h0);
		wb(1'h1, 8'h00, 4'hf, 32'h7, 32'h0, 32'h0);
		idle();
		chk("refused ops", 32'(n0), 32'(nops));
		chk("faults", 32'h0, 32'(viol));
		end_sim();
	end
endmodule

`default_nettype wire
